//--- verilog/tec_regs.svh
// register offsets, field positions, reset values and constants of the timer block
`ifndef TEC_REGS_SVH
`define TEC_REGS_SVH
`define TEC_OFF_CTRL   8'h00
`define TEC_OFF_CMD    8'h04
`define TEC_OFF_STATUS 8'h08
`define TEC_OFF_COUNT  8'h0C
`define TEC_OFF_PER    8'h10
`define TEC_OFF_CC0    8'h14
`define TEC_OFF_CC1    8'h18
`define TEC_CTRL_RST   32'h00000000
`define TEC_PER_RST    32'h000000FF
`define TEC_CMD_RETRIG 2'h1
`define TEC_CMD_STOP   2'h2
`define TEC_ST_OVF     0
`define TEC_ST_MC0     1
`define TEC_ST_ERR     3
`define TEC_ST_STOP    4
`define TEC_ST_RUN     5
`define TEC_MAX8       32'h000000FF
`define TEC_MAX16      32'h0000FFFF
`define TEC_MAX32      32'hFFFFFFFF
`endif

//--- verilog/tec_pkg.sv
// types shared by the timer block
package tec_pkg;
  typedef enum logic [1:0] {
    TEC_M16 = 2'b00,
    TEC_M8  = 2'b01,
    TEC_M32 = 2'b10
  } tec_mode_t;
  typedef enum logic [1:0] {
    TEC_NORMAL_FREQUENCY_MODE = 2'b00,
    TEC_MATCH_FREQUENCY_MODE = 2'b01,
    TEC_NORMAL_PULSE_MODULATION_MODE = 2'b10,
    TEC_MATCH_PULSE_MODULATION_MODE = 2'b11
  } tec_wave_t;
  typedef enum logic [1:0] {
    TEC_EV_OFF    = 2'b00,
    TEC_EV_RETRIG = 2'b01,
    TEC_EV_COUNT  = 2'b10,
    TEC_EV_START  = 2'b11
  } tec_evact_t;
  // control word, packed in the order of its bits in the control register
  typedef struct packed {
    logic [1:0] mceo;
    logic [1:0] inven;
    logic [1:0] copen;
    logic [1:0] capten;
    logic       tcei;
    tec_evact_t evact;
    logic       dir;
    tec_wave_t  wave;
    tec_mode_t  mode;
    logic       en;
  } tec_cfg_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } tec_bus_t;
  typedef struct packed {
    tec_cfg_t        cfg;
    logic            en_p;
    logic            run;
    logic            stop;
    logic            ovf;
    logic [1:0]      mc;
    logic            err;
    logic [31:0]     cnt;
    logic [31:0]     cycle_length_reg;
    logic [1:0][31:0] cc;
    logic [31:0]     top;
    logic [1:0]      wave;
    logic [1:0]      pin;
    logic            ovf_evt;
    logic [1:0]      mc_evt;
    logic [31:0]     rdata;
    logic [1:0]      sy1;
    logic [1:0]      sy2;
    logic [1:0]      sy3;
  } tec_state_t;
endpackage

//--- verilog/tec_timer.sv
// timer/counter with event actions, compare waveforms and input capture
//
// Overview of operation
// R1: restart from command code 1 or event
// R2: running restart reloads TOP down, zero up
// R3: stopped restart resumes from current count
// R4: restart action: enable alone does not start
// R5: count action: each event steps counter
// R6: start action: event starts, ignored while running
// R7: channels reset into compare mode
// R8: match sets channel flag on counter tick
// R9: normal modes: TOP is period or max
// R10: normal frequency toggles output on match
// R11: match frequency: TOP compare zero, toggle
// R12: pwm up: set at TOP, clear on match
// R13: pwm down: clear at zero, set on match
// R14: match pwm: low pulse on output zero
// R15: update and wrap flag at TOP/zero
// R16: TOP below count lets counter wrap
// R17: TOP change may reload old TOP once
// R18: software enables event input and capture
// R19: capture from event or synchronised pin
// R20: counter actions use only routed events
// R21: capture stores count, sets channel flag
// R22: capture while flag set raises error
// R23: direction bit zero up, one down
// R24: stop reloads start, clears waves, sets stop flag
// R25: per-channel inversion after waveform generation
`timescale 1ns/1ns
`include "tec_regs.svh"
module tec_timer (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire tec_pkg::tec_bus_t bus_i,
  output logic [31:0]          rdata_o,
  input  wire logic            event_i,
  input  wire logic [1:0]      cap_pin_i,
  output logic [1:0]           waveform_out_o,
  output logic [1:0]           waveform_oe_o,
  output logic                 wrap_event_o,
  output logic [1:0]           match_event_o,
  output logic                 running_o
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [31:0] mode_max(input tec_pkg::tec_mode_t m);
    if (m == tec_pkg::TEC_M8) begin
      mode_max = `TEC_MAX8;
    end else if (m == tec_pkg::TEC_M32) begin
      mode_max = `TEC_MAX32;
    end else begin
      mode_max = `TEC_MAX16;
    end
  endfunction

  function automatic logic hit(input tec_pkg::tec_bus_t b, input logic [7:0] off);
    hit = b.wr && (b.addr == off);
  endfunction

  // ****************************************
  // state and helper terms
  // ****************************************
  tec_pkg::tec_state_t q;
  tec_pkg::tec_state_t d;
  logic [31:0]         top_now;
  logic [31:0]         start_val;
  logic [31:0]         mask;
  logic                cmd_wr;
  logic                retrig;
  logic                stop_cmd;
  logic                start_ev;
  logic                tick;
  logic                at_end;
  logic [1:0]          match;
  logic [1:0]          pin_rise;
  logic [1:0]          cap_trig;

  assign mask   = mode_max(q.cfg.mode);
  assign cmd_wr = hit(bus_i, `TEC_OFF_CMD);

  always_comb begin
    if (q.cfg.wave == tec_pkg::TEC_MATCH_FREQUENCY_MODE || q.cfg.wave == tec_pkg::TEC_MATCH_PULSE_MODULATION_MODE) begin
      top_now = q.cc[0] & mask; // R11 R14
    end else if (q.cfg.mode == tec_pkg::TEC_M8) begin
      top_now = q.cycle_length_reg & mask; // R9
    end else begin
      top_now = mask; // R9
    end
  end

  // the reload uses the TOP copy of the previous cycle, so a late write costs one period
  assign start_val = q.cfg.dir ? q.top : 32'h00000000; // R17 R23
  assign retrig    = (cmd_wr && bus_i.wdata[1:0] == `TEC_CMD_RETRIG) ||
                     (event_i && q.cfg.en && q.cfg.evact == tec_pkg::TEC_EV_RETRIG); // R1 R20
  assign stop_cmd  = cmd_wr && bus_i.wdata[1:0] == `TEC_CMD_STOP;
  assign start_ev  = event_i && q.cfg.en && !q.run &&
                     q.cfg.evact == tec_pkg::TEC_EV_START; // R6 R20
  assign tick      = q.run && !retrig && !stop_cmd &&
                     (q.cfg.evact != tec_pkg::TEC_EV_COUNT || event_i); // R5
  // equality only: a TOP below the count is passed and the counter wraps at max
  assign at_end    = q.cfg.dir ? (q.cnt == 32'h00000000) : (q.cnt == q.top); // R15 R16
  assign pin_rise  = q.sy2 & ~q.sy3; // R19

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      assign match[gi]    = !q.cfg.capten[gi] && (q.cnt == (q.cc[gi] & mask)); // R7
      assign cap_trig[gi] = q.cfg.capten[gi] &&
                            ((q.cfg.tcei && event_i) ||
                             (q.cfg.copen[gi] && pin_rise[gi])); // R18 R19
    end
  endgenerate

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d         = q;
    d.ovf_evt = 1'b0;
    d.mc_evt  = 2'b00;
    d.rdata   = 32'h00000000;
    d.sy1     = cap_pin_i;
    d.sy2     = q.sy1;
    d.sy3     = q.sy2;
    d.top     = top_now;
    d.en_p    = q.cfg.en;

    // status clear first so that a hardware set in the same cycle wins
    if (hit(bus_i, `TEC_OFF_STATUS)) begin
      if (bus_i.wdata[`TEC_ST_OVF]) begin
        d.ovf = 1'b0;
      end
      if (bus_i.wdata[`TEC_ST_MC0]) begin
        d.mc[0] = 1'b0;
      end
      if (bus_i.wdata[`TEC_ST_MC0 + 1]) begin
        d.mc[1] = 1'b0;
      end
      if (bus_i.wdata[`TEC_ST_ERR]) begin
        d.err = 1'b0;
      end
    end

    // enable edge: restart and start actions wait for an event
    if (!q.cfg.en) begin
      d.run = 1'b0;
    end else if (!q.en_p && q.cfg.evact != tec_pkg::TEC_EV_RETRIG &&
                 q.cfg.evact != tec_pkg::TEC_EV_START) begin
      d.run  = 1'b1; // R4 R6
      d.stop = 1'b0;
    end

    if (stop_cmd && q.run) begin
      d.cnt  = start_val; // R24
      d.wave = 2'b00; // R24
      d.stop = 1'b1; // R24
      d.run  = 1'b0;
    end else if (retrig && q.cfg.en) begin
      if (q.run) begin
        d.cnt = start_val; // R2
      end else begin
        d.run  = 1'b1; // R3 R4
        d.stop = 1'b0;
      end
    end else if (start_ev) begin
      d.run  = 1'b1; // R6
      d.stop = 1'b0;
    end

    if (tick) begin
      if (at_end) begin
        d.cnt     = q.cfg.dir ? q.top : 32'h00000000; // R15
        d.ovf     = 1'b1; // R15
        d.ovf_evt = 1'b1;
      end else if (q.cfg.dir) begin
        d.cnt = (q.cnt - 32'h00000001) & mask; // R23
      end else begin
        d.cnt = (q.cnt + 32'h00000001) & mask; // R23
      end
      for (int i = 0; i < 2; i++) begin
        if (match[i]) begin
          d.mc[i]     = 1'b1; // R8
          d.mc_evt[i] = q.cfg.mceo[i]; // R8
        end
      end
      case (q.cfg.wave)
        tec_pkg::TEC_NORMAL_FREQUENCY_MODE: begin
          for (int i = 0; i < 2; i++) begin
            if (match[i]) begin
              d.wave[i] = ~q.wave[i]; // R10
            end
          end
        end
        tec_pkg::TEC_MATCH_FREQUENCY_MODE: begin
          if (at_end) begin
            d.wave[0] = ~q.wave[0]; // R11
          end
          if (match[1]) begin
            d.wave[1] = ~q.wave[1];
          end
        end
        tec_pkg::TEC_NORMAL_PULSE_MODULATION_MODE: begin
          for (int i = 0; i < 2; i++) begin
            if (at_end) begin
              d.wave[i] = ~q.cfg.dir; // R12 R13
            end else if (match[i]) begin
              d.wave[i] = q.cfg.dir; // R12 R13
            end
          end
        end
        default: begin
          if (at_end) begin
            d.wave[1] = ~q.cfg.dir; // R14
          end else if (match[1]) begin
            d.wave[1] = q.cfg.dir; // R14
          end
        end
      endcase
    end

    // match pwm output zero idles high and dips for one clock at each wrap
    if (q.cfg.wave == tec_pkg::TEC_MATCH_PULSE_MODULATION_MODE) begin
      d.wave[0] = d.run && !(tick && at_end); // R14
    end

    for (int i = 0; i < 2; i++) begin
      if (cap_trig[i]) begin
        if (q.mc[i]) begin
          d.err = 1'b1; // R22
        end else begin
          d.cc[i] = q.cnt; // R21
          d.mc[i] = 1'b1; // R21
        end
      end
    end

    if (bus_i.wr) begin
      if (bus_i.addr == `TEC_OFF_CTRL) begin
        d.cfg = tec_pkg::tec_cfg_t'(bus_i.wdata[16:0]);
      end else if (bus_i.addr == `TEC_OFF_COUNT) begin
        d.cnt = bus_i.wdata & mask; // software write beats every counter action
      end else if (bus_i.addr == `TEC_OFF_PER) begin
        d.cycle_length_reg = bus_i.wdata & `TEC_MAX8;
      end else if (bus_i.addr == `TEC_OFF_CC0) begin
        d.cc[0] = bus_i.wdata;
      end else if (bus_i.addr == `TEC_OFF_CC1) begin
        d.cc[1] = bus_i.wdata;
      end
    end

    if (bus_i.rd) begin
      if (bus_i.addr == `TEC_OFF_CTRL) begin
        d.rdata = {15'h0000, q.cfg};
      end else if (bus_i.addr == `TEC_OFF_STATUS) begin
        d.rdata = {26'h0000000, q.run, q.stop, q.err, q.mc, q.ovf};
      end else if (bus_i.addr == `TEC_OFF_COUNT) begin
        d.rdata = q.cnt;
      end else if (bus_i.addr == `TEC_OFF_PER) begin
        d.rdata = q.cycle_length_reg;
      end else if (bus_i.addr == `TEC_OFF_CC0) begin
        d.rdata = q.cc[0];
      end else if (bus_i.addr == `TEC_OFF_CC1) begin
        d.rdata = q.cc[1];
      end else begin
        d.rdata = 32'h00000000;
      end
    end

    d.pin = d.wave ^ d.cfg.inven; // R25
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q     <= '0;
      q.cfg <= tec_pkg::tec_cfg_t'(17'(`TEC_CTRL_RST)); // R7
      q.cycle_length_reg <= `TEC_PER_RST;
      q.top <= `TEC_MAX16;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata_o        = q.rdata;
  assign waveform_out_o = q.pin;
  assign waveform_oe_o  = ~q.cfg.capten;
  assign wrap_event_o   = q.ovf_evt;
  assign match_event_o  = q.mc_evt;
  assign running_o      = q.run;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_restart_run;
    retrig && q.cfg.en && q.run && !stop_cmd;
  endsequence
  sequence s_restart_idle;
    retrig && q.cfg.en && !q.run && !stop_cmd && !bus_i.wr;
  endsequence
  // a counted step that lands on TOP or zero, with no software write beside it
  sequence s_wrap_tick;
    tick && at_end && !bus_i.wr;
  endsequence
  sequence s_plain_tick;
    tick && !at_end && !bus_i.wr;
  endsequence

  chk_capture_store: assert property ( // R21
    cap_trig[0] && !q.mc[0] && !bus_i.wr |=> q.mc[0] && q.cc[0] == $past(q.cnt))
    else $error("capture did not store count");
  chk_count_step: assert property ( // R5
    s_plain_tick ##0 (q.cfg.evact == tec_pkg::TEC_EV_COUNT && !q.cfg.dir && q.cnt != mask)
    |=> q.cnt == $past(q.cnt) + 32'h00000001)
    else $error("count event did not step counter");
  chk_match_frequency_mode_toggle: assert property ( // R11
    s_wrap_tick ##0 (q.cfg.wave == tec_pkg::TEC_MATCH_FREQUENCY_MODE) |=> q.wave[0] != $past(q.wave[0]))
    else $error("match frequency output did not toggle");
  chk_normal_pulse_modulation_mode_set: assert property ( // R12
    s_wrap_tick ##0 (q.cfg.wave == tec_pkg::TEC_NORMAL_PULSE_MODULATION_MODE && !q.cfg.dir) |=> q.wave[0])
    else $error("pwm up output not set at TOP");
  chk_normal_pulse_modulation_mode_down: assert property ( // R13
    s_plain_tick ##0 (q.cfg.wave == tec_pkg::TEC_NORMAL_PULSE_MODULATION_MODE && q.cfg.dir && match[0])
    |=> q.wave[0])
    else $error("pwm down output not set on match");
  chk_match_pulse_modulation_mode_pulse: assert property ( // R14
    s_wrap_tick ##0 (q.cfg.wave == tec_pkg::TEC_MATCH_PULSE_MODULATION_MODE) |=> !q.wave[0] && q.ovf_evt)
    else $error("match pwm wrap pulse missing");
  chk_normal_frequency_mode_toggle: assert property ( // R10
    s_plain_tick ##0 (q.cfg.wave == tec_pkg::TEC_NORMAL_FREQUENCY_MODE && match[1])
    |=> q.wave[1] != $past(q.wave[1]))
    else $error("normal frequency output did not toggle");

  chk_restart_clear: assert property ( // R2
    s_restart_run ##0 (!q.cfg.dir && !bus_i.wr) |=> q.cnt == 32'h00000000)
    else $error("running restart did not clear counter");
  chk_restart_resume: assert property ( // R3
    s_restart_idle |=> q.run && q.cnt == $past(q.cnt))
    else $error("stopped restart did not resume");
  chk_enable_wait: assert property ( // R4
    (q.cfg.en && !q.en_p && !q.run && !event_i && !bus_i.wr &&
     q.cfg.evact == tec_pkg::TEC_EV_RETRIG) |=> !q.run)
    else $error("restart action started on enable");
  chk_count_event: assert property ( // R5
    (q.run && q.cfg.evact == tec_pkg::TEC_EV_COUNT && !event_i && !bus_i.wr)
    |=> $stable(q.cnt))
    else $error("counter moved without event");
  chk_start_ignore: assert property ( // R6
    (start_ev || (q.run && q.cfg.en && event_i)) && !stop_cmd &&
    q.cfg.evact == tec_pkg::TEC_EV_START && !bus_i.wr |=> q.run)
    else $error("start event not honoured");
  chk_match_flag: assert property ( // R8
    tick && match[0] |=> q.mc[0])
    else $error("match flag not set");
  chk_wrap_flag: assert property ( // R15
    tick && at_end && !bus_i.wr |=> q.ovf && q.ovf_evt ##1 !q.ovf_evt)
    else $error("wrap flag or event wrong");
  chk_capture_err: assert property ( // R22
    cap_trig[0] && q.mc[0] && !bus_i.wr |=> q.err && $stable(q.cc[0]))
    else $error("capture overflow not handled");
  chk_stop_clear: assert property ( // R24
    stop_cmd && q.run |=> q.stop && !q.run && q.wave == 2'b00)
    else $error("stop did not clear state");
endmodule

//--- dv/tec_far_model.sv
// far-side model: event routing network and the two capture/waveform pins
`timescale 1ns/1ns
module tec_far_model (
  input  wire logic       clk_i,
  input  wire logic       ev_req_i,
  input  wire logic [1:0] pin_req_i,
  input  wire logic [1:0] wave_i,
  input  wire logic [1:0] oe_i,
  output logic            event_o = 1'b0,
  output logic [1:0]      cap_pin_o
);
  // ****************************************************
  // event network
  // ****************************************************
  // events leave the network one clock after the request, registered in the timer clock domain
  always @(posedge clk_i) begin
    event_o <= ev_req_i;
  end
  // ****************************************************
  // pin level
  // ****************************************************
  // the timer owns the pin while its enable is high, else the outside source drives it
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cap_pin_o[i] = oe_i[i] ? wave_i[i] : pin_req_i[i];
    end
  end
endmodule

//--- dv/timer_event_compare_capture_test.sv
// self-checking testbench of the timer block
`timescale 1ns/1ns
`include "tec_regs.svh"
module timer_event_compare_capture_test;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  tec_pkg::tec_bus_t bus = '0;
  logic [31:0]      rdata;
  logic             ev_req = 1'b0;
  logic [1:0]       pin_req = 2'b00;
  logic             event_w;
  logic [1:0]       cap_w;
  logic [1:0]       wave;
  logic [1:0]       oe;
  logic             wrap;
  logic             running;
  int               mismatches = 0;
  int               num_checks = 0;
  logic [31:0]      v;
  logic [31:0]      cap;
  tec_pkg::tec_cfg_t cfg;
  int               n;

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  tec_timer uut (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .bus_i          (bus),
    .rdata_o        (rdata),
    .event_i        (event_w),
    .cap_pin_i      (cap_w),
    .waveform_out_o (wave),
    .waveform_oe_o  (oe),
    .wrap_event_o   (wrap),
    .match_event_o  (),
    .running_o      (running)
  );

  tec_far_model far (
    .clk_i     (clk_i),
    .ev_req_i  (ev_req),
    .pin_req_i (pin_req),
    .wave_i    (wave),
    .oe_i      (oe),
    .event_o   (event_w),
    .cap_pin_o (cap_w)
  );

  // ****************************************************
  // bus and event tasks
  // ****************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_i);
    bus <= '0;
    #1 d = rdata;
  endtask

  task automatic evt();
    @(posedge clk_i);
    ev_req <= 1'b1;
    @(posedge clk_i);
    ev_req <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic do_reset(input string name);
    $display("test done: %s", name);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    cfg = '0;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************************
  // tests
  // ****************************************************
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    cfg = '0;
    // reset values, compare mode on both channels, unmapped place reads zero
    chk(32'(oe), 32'h3);
    rd(`TEC_OFF_CTRL, v);
    chk(v, `TEC_CTRL_RST);
    rd(`TEC_OFF_PER, v);
    chk(v, `TEC_PER_RST);
    rd(8'h1C, v);
    chk(v, 32'h0);
    // restart action: enable alone does not start, the event does
    cfg.evact = tec_pkg::TEC_EV_RETRIG;
    cfg.en = 1'b1;
    wr(`TEC_OFF_CTRL, 32'(cfg));
    repeat (4) @(posedge clk_i);
    chk(32'(running), 32'h0);
    evt();
    chk(32'(running), 32'h1);
    repeat (20) @(posedge clk_i);
    wr(`TEC_OFF_CMD, 32'(`TEC_CMD_RETRIG));
    rd(`TEC_OFF_COUNT, v);
    chk(32'(v < 32'h8), 32'h1);
    // stop loads zero, then a restart resumes from a written count
    wr(`TEC_OFF_CMD, 32'(`TEC_CMD_STOP));
    rd(`TEC_OFF_STATUS, v);
    chk(32'({v[`TEC_ST_STOP], v[`TEC_ST_RUN]}), 32'h2);
    chk(32'(wave), 32'h0);
    wr(`TEC_OFF_COUNT, 32'h40);
    wr(`TEC_OFF_CMD, 32'(`TEC_CMD_RETRIG));
    rd(`TEC_OFF_COUNT, v);
    chk(32'(v >= 32'h40 && v < 32'h48), 32'h1);
    do_reset("restart");
    // count action: events step the counter up, then down
    cfg.evact = tec_pkg::TEC_EV_COUNT;
    cfg.en = 1'b1;
    wr(`TEC_OFF_CTRL, 32'(cfg));
    repeat (5) evt();
    rd(`TEC_OFF_COUNT, v);
    chk(v, 32'h5);
    cfg.dir = 1'b1;
    wr(`TEC_OFF_CTRL, 32'(cfg));
    repeat (3) evt();
    rd(`TEC_OFF_COUNT, v);
    chk(v, 32'h2);
    do_reset("count");
    // start action: enable waits for the event
    cfg.evact = tec_pkg::TEC_EV_START;
    cfg.en = 1'b1;
    wr(`TEC_OFF_CTRL, 32'(cfg));
    repeat (4) @(posedge clk_i);
    chk(32'(running), 32'h0);
    evt();
    chk(32'(running), 32'h1);
    evt();
    chk(32'(running), 32'h1);
    do_reset("start");
    // event capture on channel 0, then overflow while its flag is up
    cfg.tcei = 1'b1;
    cfg.capten = 2'b01;
    cfg.en = 1'b1;
    wr(`TEC_OFF_CTRL, 32'(cfg));
    #1;
    chk(32'(oe), 32'h2);
    repeat (10) @(posedge clk_i);
    evt();
    rd(`TEC_OFF_CC0, cap);
    rd(`TEC_OFF_COUNT, v);
    chk(32'(cap != 32'h0 && cap < v), 32'h1);
    rd(`TEC_OFF_STATUS, v);
    chk(32'({v[`TEC_ST_ERR], v[`TEC_ST_MC0]}), 32'h1);
    evt();
    rd(`TEC_OFF_CC0, v);
    chk(v, cap);
    rd(`TEC_OFF_STATUS, v);
    chk(32'(v[`TEC_ST_ERR]), 32'h1);
    // pin capture on channel 0 after clearing the flags
    wr(`TEC_OFF_STATUS, 32'hF);
    cfg.copen = 2'b01;
    wr(`TEC_OFF_CTRL, 32'(cfg));
    pin_req <= 2'b01;
    repeat (6) @(posedge clk_i);
    rd(`TEC_OFF_STATUS, v);
    chk(32'({v[`TEC_ST_ERR], v[`TEC_ST_MC0]}), 32'h1);
    do_reset("capture");
    // normal frequency, 8-bit with period 16: channel 1 toggles once per period
    pin_req <= 2'b00;
    wr(`TEC_OFF_PER, 32'hF);
    wr(`TEC_OFF_CC1, 32'h5);
    cfg.mode = tec_pkg::TEC_M8;
    cfg.en = 1'b1;
    wr(`TEC_OFF_CTRL, 32'(cfg));
    repeat (3) @(posedge clk_i);
    n = 0;
    v[0] = wave[1];
    repeat (64) begin
      @(posedge clk_i);
      #1 n += (wave[1] != v[0]);
      v[0] = wave[1];
    end
    chk(32'(n), 32'h4);
    rd(`TEC_OFF_STATUS, v);
    chk(32'(v[`TEC_ST_MC0 + 1]), 32'h1);
    do_reset("frequency");
    // match pwm: TOP from compare zero, one wrap pulse per period of 10
    wr(`TEC_OFF_CC0, 32'h9);
    cfg.wave = tec_pkg::TEC_MATCH_PULSE_MODULATION_MODE;
    cfg.inven = 2'b10;
    cfg.en = 1'b1;
    wr(`TEC_OFF_CTRL, 32'(cfg));
    repeat (3) @(posedge clk_i);
    n = 0;
    v = 32'h0;
    repeat (40) begin
      @(posedge clk_i);
      #1 n += wrap;
      v += 32'(!wave[0]);
    end
    chk(32'(n), 32'h4);
    chk(v, 32'h4);
    do_reset("match pwm");
    report_and_stop();
  end

  // ****************************************************
  // watchdog
  // ****************************************************
  // the tests take well under 2000 cycles, so this only fires on a hang
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
endmodule
